// File: srs_consts.vh
`ifndef SRS_CONSTS_VH
`define SRS_CONSTS_VH
`define SRS_CLK_MHZ         50
`define SRS_PWR_OK_MS       200
`define SRS_BRIDGE_MS       2
`define SRS_STABLE_US       15
`define SRS_HUB_CLKS        4000
`define SRS_CPU_CLKS        200000
`define SRS_LPC_CLKS        2
`define SRS_STALL_CLKS      3000
`define SRS_MEM_CLKS        4
`define SRS_LINK_CLKS       16
`define SRS_SYNC_IDLE       7'h40
`define SRS_PWR_OK_CYC      (`SRS_PWR_OK_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_BRIDGE_CYC      (`SRS_BRIDGE_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_STABLE_CYC      (`SRS_STABLE_US * `SRS_CLK_MHZ)
`endif

// File: srs_sequencer.v
`include "srs_consts.vh"

module srs_sequencer #(
    parameter PWR_OK_CYC = `SRS_PWR_OK_CYC,
    parameter BRIDGE_CYC = `SRS_BRIDGE_CYC,
    parameter CPU_CLKS   = `SRS_CPU_CLKS,
    parameter HUB_CLKS   = `SRS_HUB_CLKS,
    parameter STALL_CLKS = `SRS_STALL_CLKS,
    parameter STABLE_CYC = `SRS_STABLE_CYC
) (
    input  wire core_clk,
    input  wire sys_rst,
    input  wire clk18Good,
    input  wire cpu18Good,
    input  wire pwr33Good,
    input  wire clk66Stable,
    input  wire lpcClkTick,
    input  wire memClkTick,
    input  wire pciResetN,
    output reg  io_clock_enable,
    output reg  processor_clock_enable,
    output reg  system_power_ok,
    output reg  hub_power_ok,
    output reg  bridge_reset_n,
    output reg  pci_bus_reset_n,
    output reg  hard_reset_request_n,
    output reg  hubResetBusy,
    output reg  hubLinkStart,
    output reg  processorResetN,
    output reg  lpc_side_reset_n,
    output reg  bus_stall_hold_n,
    output reg  memory_reset_n
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: two flip-flops per asynchronous input
localparam              SYNC_W    = 7;
localparam [SYNC_W-1:0] SYNC_IDLE = `SRS_SYNC_IDLE;

wire [SYNC_W-1:0] rawIn;
wire [SYNC_W-1:0] syncOut;
reg               lpcPrev_r;
reg               memPrev_r;

assign rawIn = {pciResetN, memClkTick, lpcClkTick, clk66Stable, pwr33Good, cpu18Good, clk18Good};

genvar gi;
generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : gSync
        reg meta_r;
        reg sync_r;
        always @(posedge core_clk) begin
            if (sys_rst) begin
                meta_r <= SYNC_IDLE[gi];
                sync_r <= SYNC_IDLE[gi];
            end else begin
                meta_r <= rawIn[gi];
                sync_r <= meta_r;
            end
        end
        assign syncOut[gi] = sync_r;
    end
endgenerate

wire clk18S  = syncOut[0];
wire cpu18S  = syncOut[1];
wire pwr33S  = syncOut[2];
wire stableS = syncOut[3];
wire lpcS    = syncOut[4];
wire memS    = syncOut[5];
wire pciRstS = ~syncOut[6];
wire lpcEdge = lpcS & ~lpcPrev_r;
wire memEdge = memS & ~memPrev_r;

////////////////////////////////////////////////////////////////////////////////
// Rising-edge detectors for the sampled slow clocks, low after reset like the idle pins
always @(posedge core_clk) begin
    if (sys_rst) begin
        lpcPrev_r <= 1'b0;
        memPrev_r <= 1'b0;
    end else begin
        lpcPrev_r <= lpcS;
        memPrev_r <= memS;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power-on part: clock enables, power ok, bridge reset
reg  [31:0] pwrCnt_r;
reg  [31:0] brCnt_r;
reg  [31:0] stabCnt_r;
reg  [4:0]  linkCnt_r;
reg         bridgeDone_r;

always @(posedge core_clk) begin
    if (sys_rst) begin
        io_clock_enable        <= 1'b0;
        processor_clock_enable <= 1'b0;
        system_power_ok        <= 1'b0;
        hub_power_ok           <= 1'b0;
        pwrCnt_r               <= 32'h0;
        brCnt_r                <= 32'h0;
        stabCnt_r              <= 32'h0;
        bridge_reset_n         <= 1'b0;
        pci_bus_reset_n        <= 1'b0;
        bridgeDone_r           <= 1'b0;
        linkCnt_r              <= 5'h0;
        hubLinkStart           <= 1'b0;
    end else begin
        io_clock_enable        <= clk18S & pwr33S;
        processor_clock_enable <= cpu18S & pwr33S;
        if (!pwr33S) begin
            pwrCnt_r        <= 32'h0;
            system_power_ok <= 1'b0;
        end else if (pwrCnt_r == PWR_OK_CYC) begin
            system_power_ok <= 1'b1;
        end else begin
            pwrCnt_r <= pwrCnt_r + 32'h1;
        end
        hub_power_ok <= system_power_ok;
        stabCnt_r <= !stableS ? 32'h0 : (stabCnt_r == STABLE_CYC ? stabCnt_r : stabCnt_r + 32'h1);
        if (!system_power_ok) begin
            brCnt_r        <= 32'h0;
            bridgeDone_r   <= 1'b0;
            bridge_reset_n <= 1'b0;
        end else if (brCnt_r != BRIDGE_CYC) begin
            brCnt_r <= brCnt_r + 32'h1;
        end else if (stabCnt_r == STABLE_CYC) begin
            bridge_reset_n <= 1'b1;
            bridgeDone_r   <= 1'b1;
        end
        pci_bus_reset_n <= bridge_reset_n;
        if (!bridge_reset_n) begin
            linkCnt_r    <= 5'h0;
            hubLinkStart <= 1'b0;
        end else if (linkCnt_r != `SRS_LINK_CLKS) begin
            linkCnt_r <= linkCnt_r + 5'h1;
        end else begin
            hubLinkStart <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Hard reset cascade, shared by power-on and system hard reset
reg  [31:0] hubCnt_r;
reg  [31:0] cpuCnt_r;
reg  [31:0] stallCnt_r;
wire        cascadeHold = !bridgeDone_r | pciRstS;

// A PCI reset pulse restarts this cascade and the LPC and memory resets behind it; power ok and the bridge reset stay
always @(posedge core_clk) begin
    if (sys_rst) begin
        hard_reset_request_n <= 1'b0;
        hubResetBusy         <= 1'b1;
        hubCnt_r             <= 32'h0;
        cpuCnt_r             <= 32'h0;
        processorResetN      <= 1'b0;
        stallCnt_r           <= 32'h0;
        bus_stall_hold_n     <= 1'b0;
    end else begin
        hard_reset_request_n <= ~cascadeHold;
        if (!hard_reset_request_n) begin
            hubCnt_r        <= 32'h0;
            hubResetBusy    <= 1'b1;
            cpuCnt_r        <= 32'h0;
            processorResetN <= 1'b0;
        end else begin
            if (hubCnt_r != HUB_CLKS) hubCnt_r <= hubCnt_r + 32'h1;
            else hubResetBusy <= 1'b0;
            if (cpuCnt_r != CPU_CLKS) cpuCnt_r <= cpuCnt_r + 32'h1;
            else processorResetN <= 1'b1;
        end
        if (!hard_reset_request_n) begin
            stallCnt_r       <= 32'h0;
            bus_stall_hold_n <= 1'b0;
        end else if (stallCnt_r != STALL_CLKS) begin
            stallCnt_r <= stallCnt_r + 32'h1;
        end else begin
            bus_stall_hold_n <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Low-pin-count and memory resets, each counted in rising edges of its own clock
reg  [1:0]  lpcCnt_r;
reg  [3:0]  memCnt_r;

always @(posedge core_clk) begin
    if (sys_rst) begin
        lpcCnt_r         <= 2'h0;
        lpc_side_reset_n <= 1'b0;
    end else if (!processorResetN) begin
        lpcCnt_r         <= 2'h0;
        lpc_side_reset_n <= 1'b0;
    end else if (lpcCnt_r != `SRS_LPC_CLKS) begin
        if (lpcEdge) begin
            lpcCnt_r <= lpcCnt_r + 2'h1;
        end
    end else begin
        lpc_side_reset_n <= 1'b1;
    end
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        memCnt_r       <= 4'h0;
        memory_reset_n <= 1'b0;
    end else if (!bus_stall_hold_n) begin
        memCnt_r       <= 4'h0;
        memory_reset_n <= 1'b0;
    end else if (memCnt_r != `SRS_MEM_CLKS) begin
        if (memEdge) begin
            memCnt_r <= memCnt_r + 4'h1;
        end
    end else begin
        memory_reset_n <= 1'b1;
    end
end

endmodule // srs_sequencer

// File: srs_props.sv
module srs_props (
    input wire core_clk,
    input wire sys_rst,
    input wire clk18Good,
    input wire cpu18Good,
    input wire pwr33Good,
    input wire clk66Stable,
    input wire pciResetN,
    input wire io_clock_enable,
    input wire processor_clock_enable,
    input wire system_power_ok,
    input wire bridge_reset_n,
    input wire pci_bus_reset_n,
    input wire hard_reset_request_n,
    input wire hubResetBusy,
    input wire hubLinkStart,
    input wire processorResetN,
    input wire lpc_side_reset_n,
    input wire bus_stall_hold_n,
    input wire memory_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_IO_EN: assert property (io_clock_enable |-> $past(clk18Good, 3) && $past(pwr33Good, 3)) else $error("io early");
    AST_PWR_OK: assert property ($rose(system_power_ok) |-> $past(pwr33Good, 10)) else $error("power ok early");
    AST_PCI_FOL: assert property (pci_bus_reset_n == $past(bridge_reset_n)) else $error("pci reset lag");
    AST_HARD_REQ: assert property (!pciResetN |-> ##3 !hard_reset_request_n) else $error("hard req missing");
    AST_HUB_BUSY: assert property ($rose(hard_reset_request_n) |-> hubResetBusy[*8] ##[1:4] !hubResetBusy) else $error("hub busy");
    AST_CPU_RST: assert property ($rose(processorResetN) |->
        $past(hard_reset_request_n, 19) && !$past(hard_reset_request_n, 23)) else $error("cpu reset len");
    AST_STALL: assert property ($rose(bus_stall_hold_n) |->
        $past(hard_reset_request_n, 5) && !$past(hard_reset_request_n, 9)) else $error("stall len");
    AST_LINK: assert property ($rose(hubLinkStart) |->
        $past(bridge_reset_n, 16) && !$past(bridge_reset_n, 18)) else $error("link start");
    AST_CPU_EN: assert property (processor_clock_enable |->
        $past(cpu18Good, 3) && $past(pwr33Good, 3)) else $error("cpu enable early");
    AST_BRIDGE_HOLD: assert property ($rose(bridge_reset_n) |->
        $past(system_power_ok, 10)) else $error("bridge released early");
    AST_BRIDGE_STABLE: assert property ($rose(bridge_reset_n) |->
        $past(clk66Stable, 4) && $past(clk66Stable, 8)) else $error("bridge before stable clock");
    AST_LPC_OFF: assert property ($rose(lpc_side_reset_n) |->
        $past(processorResetN, 4) && !$past(processorResetN, 6)) else $error("lpc reset offset");
    AST_MEM_HOLD: assert property ($rose(memory_reset_n) |->
        $past(bus_stall_hold_n, 8)) else $error("memory reset early");
endmodule // srs_props
bind srs_sequencer srs_props u_props (.*);

// File: srs_partner.sv
module srs_partner (
    input  wire  hubPowerOk,
    input  wire  pulseReq,
    output logic lpcClkTick,
    output logic memClkTick,
    output wire  pciResetN
);
    timeunit 1ns;
    timeprecision 1ps;
    // South bridge holds PCI reset until its power is good
    assign pciResetN = hubPowerOk & ~pulseReq;
    initial begin
        lpcClkTick = 1'h0;
        forever #20 lpcClkTick = ~lpcClkTick;
    end
    initial begin
        memClkTick = 1'h0;
        forever #40 memClkTick = ~memClkTick;
    end
endmodule // srs_partner

// File: tb_top.sv
`include "srs_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errorCnt++; $display("ERROR %s exp %b got %b", n, e, g); end end
    logic core_clk, sys_rst, clk18Good, cpu18Good, pwr33Good, clk66Stable, pulseReq;
    wire  lpcClkTick, memClkTick, pciResetN, io_clock_enable, processor_clock_enable, system_power_ok;
    wire  hub_power_ok, bridge_reset_n, pci_bus_reset_n, hard_reset_request_n, hubResetBusy, hubLinkStart;
    wire  processorResetN, lpc_side_reset_n, bus_stall_hold_n, memory_reset_n;
    int   errorCnt, testsRun;
    srs_sequencer #(.PWR_OK_CYC(10), .BRIDGE_CYC(10), .CPU_CLKS(20), .HUB_CLKS(8), .STALL_CLKS(6)) DUT (.*);
    srs_partner partner (.hubPowerOk(hub_power_ok), .pulseReq(pulseReq), .lpcClkTick(lpcClkTick),
        .memClkTick(memClkTick), .pciResetN(pciResetN));
    task automatic finishTest();
        $display("Checks %0d errors %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic waitLpc(input int n);
        repeat (n) if (lpc_side_reset_n !== 1'h1 || memory_reset_n !== 1'h1) @(negedge core_clk);
    endtask
    task automatic testPowerOn();
        pwr33Good = 1'h1;
        clk18Good = 1'h1;
        cyc(2);
        `CHK("ioEnEarly", 1'h0, io_clock_enable)
        `CHK("cpuEnNoSupply", 1'h0, processor_clock_enable)
        cyc(1);
        `CHK("ioEn", 1'h1, io_clock_enable)
        `CHK("pwrOkEarly", 1'h0, system_power_ok)
        cpu18Good = 1'h1;
        cyc(20);
        `CHK("cpuEn", 1'h1, processor_clock_enable)
        `CHK("pwrOk", 1'h1, system_power_ok)
        cyc(10);
        `CHK("bridgeNoClk", 1'h0, bridge_reset_n)
        clk66Stable = 1'h1;
        cyc(`SRS_STABLE_CYC + 2);
        `CHK("bridgeStable", 1'h0, bridge_reset_n)
        cyc(1);
        `CHK("bridgeRel", 1'h1, bridge_reset_n)
        waitLpc(300);
        `CHK("lpcRst", 1'h1, lpc_side_reset_n)
        `CHK("bridge", 1'h1, bridge_reset_n)
        `CHK("pciBus", 1'h1, pci_bus_reset_n)
        `CHK("memRst", 1'h1, memory_reset_n)
        `CHK("hubBusy", 1'h0, hubResetBusy)
        `CHK("linkStart", 1'h1, hubLinkStart)
    endtask
    task automatic testHardReset();
        pulseReq = 1'h1;
        cyc(8);
        `CHK("hardReq", 1'h0, hard_reset_request_n)
        `CHK("cpuInReset", 1'h0, processorResetN)
        `CHK("stallHeld", 1'h0, bus_stall_hold_n)
        `CHK("memHeld", 1'h0, memory_reset_n)
        `CHK("pwrOkKept", 1'h1, system_power_ok)
        `CHK("bridgeKept", 1'h1, bridge_reset_n)
        pulseReq = 1'h0;
        cyc(20);
        `CHK("cpuHold", 1'h0, processorResetN)
        waitLpc(300);
        `CHK("cpuBack", 1'h1, processorResetN)
        `CHK("memBack", 1'h1, memory_reset_n)
    endtask
    task automatic testPowerDrop();
        pwr33Good = 1'h0;
        cyc(4);
        `CHK("pwrOkDrop", 1'h0, system_power_ok)
        `CHK("ioEnDrop", 1'h0, io_clock_enable)
        `CHK("cpuEnDrop", 1'h0, processor_clock_enable)
        cyc(2);
        `CHK("bridgeDrop", 1'h0, bridge_reset_n)
        `CHK("hardDrop", 1'h0, hard_reset_request_n)
    endtask
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        {sys_rst, clk18Good, cpu18Good, pwr33Good, clk66Stable, pulseReq} = 6'h20;
        cyc(10);
        sys_rst = 1'h0;
        testPowerOn();
        testHardReset();
        testPowerDrop();
        finishTest();
    end
    initial begin
        #40000;
        errorCnt++;
        finishTest();
    end
endmodule // tb_top
